/* File: src/mfi_cfg.svh */
// Register offsets, field positions, masks, reset values and status bit positions
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// Byte offsets on the bus (chosen)
`define OFS_GROUP_A      8'h00
`define OFS_GROUP_B      8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_ENABLE   8'h0c
`define OFS_IRQ_CLEAR    8'h10
`define OFS_WAKE_STATUS  8'h14

// Group A field positions
`define A_T3A_FLAG   7
`define A_T3P_FLAG   6
`define A_XP_FLAG    5
`define A_SI_FLAG    4
`define A_T3A_EN     3
`define A_T3P_EN     2
`define A_XP_EN      1
`define A_SI_EN      0

// Group B field positions
`define B_SPI_FLAG   6
`define B_EE_FLAG    5
`define B_LV_FLAG    4
`define B_SPI_EN     2
`define B_EE_EN      1
`define B_LV_EN      0

// Implemented-bit masks
`define MASK_A_SMALL 8'h33
`define MASK_A_LARGE 8'hff
`define MASK_B       8'h77

// Reset values
`define RST_GROUP    8'h00
`define RST_IRQ      2'h0

// Status bit positions for the system interrupt
`define ST_GROUP_A   0
`define ST_GROUP_B   1

`endif

/* File: src/mfi_pkg.sv */
// Types shared by the multi-function interrupt register block
package mfi_pkg;

    // Peripheral event strobes, one cycle each
    typedef struct packed {
        logic timer3_cmp_a;
        logic timer3_cmp_p;
        logic ext_periph;
        logic serial_if;
        logic second_spi;
        logic eeprom;
        logic low_volt;
    } src_events_t;

    // Decoded bus request carried to the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_req_t;

endpackage : mfi_pkg

/* File: src/mfi_group_reg.sv */
// One 8-bit flag/enable register with hardware set and software write
`timescale 1ns/1ps
`include "mfi_cfg.svh"

module mfi_group_reg
    import mfi_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff  // Implemented bits
)(
    input  wire logic       hclk,     // System clock
    input  wire logic       hresetn,  // Async reset, active low
    input  wire logic       wr_en,    // Software write strobe
    input  wire logic [7:0] wr_data,  // Software write value
    input  wire logic [3:0] hw_set,   // Flag sets for bits 7..4
    output logic      [7:0] value,    // Register contents
    output logic            req       // Group request
);

    // State of the register
    typedef struct packed {
        logic [7:0] bits;
    } grp_state_t;

    grp_state_t s_q;  // Registered state
    grp_state_t s_d;  // Next state

    // Next value: software write, then hardware set wins
    always_comb
    begin
        s_d = s_q;
        if (wr_en)
        begin
            s_d.bits = wr_data & IMPL_MASK;
        end
        // Set regardless of enable; set beats a clearing write
        s_d.bits[7:4] = s_d.bits[7:4] | (hw_set & IMPL_MASK[7:4]);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q.bits <= `RST_GROUP;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign value = s_q.bits;
    // Flag ANDed with its enable, ORed over the group
    assign req   = |(s_q.bits[7:4] & s_q.bits[3:0]);

endmodule : mfi_group_reg

/* File: src/mfi_regs.sv */
// Multi-function interrupt flag/enable registers behind an AHB-Lite slave
`timescale 1ns/1ps
`include "mfi_cfg.svh"

module mfi_regs
    import mfi_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1  // Timer-3 bits present
)(
    input  wire logic        hclk,       // System clock
    input  wire logic        hresetn,    // Async reset, active low
    input  wire logic        hsel,       // Slave select
    input  wire logic [7:0]  haddr,      // Byte address
    input  wire logic [1:0]  htrans,     // Transfer type
    input  wire logic        hwrite,     // Write when high
    input  wire logic [2:0]  hsize,      // Transfer size
    input  wire logic [31:0] hwdata,     // Write data
    input  wire logic        hready,     // Bus ready
    output logic      [31:0] hrdata,     // Read data
    output logic             hreadyout,  // Slave ready
    output logic             hresp,      // Always OKAY
    input  wire src_events_t ev,         // Peripheral event strobes
    output logic             mf_req_a,   // Group A request
    output logic             mf_req_b,   // Group B request
    output logic             wake,       // Wake pulse to power control
    output logic             irq         // System interrupt level
);

    localparam logic [7:0] MASK_A = LARGE_VARIANT ? `MASK_A_LARGE : `MASK_A_SMALL;

    // State of this module apart from prev_a and prev_b
    typedef struct packed {
        bus_req_t    req;       // Pending data phase
        logic [31:0] rdata;     // Read data
        logic        req_a;     // Registered group A request
        logic        req_b;     // Registered group B request
        logic        wake;      // Wake pulse
        logic [1:0]  ist;       // Sticky interrupt status
        logic [1:0]  ien;       // Interrupt enable
        logic        irq;       // Interrupt output
        logic [7:0]  wake_src;  // Which flags caused the last wake
    } state_t;

    state_t s_q;  // Registered state
    state_t s_d;  // Next state

    logic [7:0] grp_a;   // Group A contents
    logic [7:0] grp_b;   // Group B contents
    logic       comb_a;  // Group A request, combinational
    logic       comb_b;  // Group B request, combinational
    logic       wr_a;    // Write strobe, group A
    logic       wr_b;    // Write strobe, group B
    logic [3:0] set_a;   // Hardware sets, group A
    logic [3:0] set_b;   // Hardware sets, group B
    logic [7:0] prev_a;  // Flags of group A last cycle
    logic [7:0] prev_b;  // Flags of group B last cycle

    // Write strobe for a given offset during the data phase
    function automatic logic wr_hit(input bus_req_t r, input logic [7:0] ofs);
        wr_hit = r.valid && r.write && (r.addr == ofs);
    endfunction : wr_hit

    assign wr_a  = wr_hit(s_q.req, `OFS_GROUP_A);
    assign wr_b  = wr_hit(s_q.req, `OFS_GROUP_B);
    // Bits 7..4 of group A: timer-3 A, timer-3 P, ext periph, serial
    assign set_a = {ev.timer3_cmp_a, ev.timer3_cmp_p, ev.ext_periph, ev.serial_if};
    // Bits 7..4 of group B: unused, second SPI, EEPROM, low-voltage
    assign set_b = {1'b0, ev.second_spi, ev.eeprom, ev.low_volt};

    // Group A register, enables at bits 3..0
    mfi_group_reg #(
        .IMPL_MASK (MASK_A)
    ) u_group_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_a),
        .wr_data (hwdata[7:0]),
        .hw_set  (set_a),
        .value   (grp_a),
        .req     (comb_a)
    );

    // Group B register, enables at bits 2..0
    mfi_group_reg #(
        .IMPL_MASK (`MASK_B)
    ) u_group_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_b),
        .wr_data (hwdata[7:0]),
        .hw_set  (set_b),
        .value   (grp_b),
        .req     (comb_b)
    );

    // Previous flags for rising-edge detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_a <= `RST_GROUP;
            prev_b <= `RST_GROUP;
        end
        else
        begin
            prev_a <= grp_a;
            prev_b <= grp_b;
        end
    end

    // Next state of bus slave, requests, wake and interrupt
    always_comb
    begin
        logic [1:0] rise;
        logic [1:0] clr;
        logic [7:0] new_a;
        logic [7:0] new_b;
        rise  = 2'h0;
        clr   = 2'h0;
        new_a = grp_a & ~prev_a & 8'hf0;
        new_b = grp_b & ~prev_b & 8'hf0;
        s_d   = s_q;
        // Address phase capture
        s_d.req.valid = hsel && hready && htrans[1];
        s_d.req.write = hwrite;
        s_d.req.addr  = haddr;
        // Read data prepared for the next data phase
        s_d.rdata = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            unique case (haddr)
                `OFS_GROUP_A:     s_d.rdata = {24'h0, grp_a};
                `OFS_GROUP_B:     s_d.rdata = {24'h0, grp_b};
                `OFS_IRQ_STATUS:  s_d.rdata = {30'h0, s_q.ist};
                `OFS_IRQ_ENABLE:  s_d.rdata = {30'h0, s_q.ien};
                `OFS_WAKE_STATUS: s_d.rdata = {24'h0, s_q.wake_src};
                default:          s_d.rdata = 32'h0;  // Unmapped reads zero
            endcase
        end
        // Group requests to vectoring logic
        s_d.req_a = comb_a;
        s_d.req_b = comb_b;
        // Wake on any newly set flag
        s_d.wake = |{new_a, new_b};
        if (s_d.wake)
        begin
            s_d.wake_src = {new_b[7:4], new_a[7:4]};
        end
        // Software register writes
        if (wr_hit(s_q.req, `OFS_IRQ_ENABLE))
        begin
            s_d.ien = hwdata[1:0];
        end
        if (wr_hit(s_q.req, `OFS_IRQ_CLEAR))
        begin
            clr = hwdata[1:0];
        end
        // Sticky status on rising group request; set beats clear
        rise[`ST_GROUP_A] = comb_a && !s_q.req_a;
        rise[`ST_GROUP_B] = comb_b && !s_q.req_b;
        s_d.ist = (s_q.ist & ~clr) | rise;
        s_d.irq = |(s_d.ist & s_d.ien);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs from flops; hreadyout and hresp are constants
    assign hrdata    = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign mf_req_a  = s_q.req_a;
    assign mf_req_b  = s_q.req_b;
    assign wake      = s_q.wake;
    assign irq       = s_q.irq;

    // Event sets its flag one cycle later in readback
    property p_flag_set;
        @(posedge hclk) disable iff (!hresetn)
        ev.ext_periph |=> grp_a[`A_XP_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    // Enabled flag gives group request next cycle
    property p_req_a;
        @(posedge hclk) disable iff (!hresetn)
        (grp_a[`A_XP_FLAG] && grp_a[`A_XP_EN]) |=> mf_req_a;
    endproperty
    a_req_a: assert property (p_req_a) else $error("group a request missing");

    // No enables, no request
    property p_no_req;
        @(posedge hclk) disable iff (!hresetn)
        (grp_b[2:0] == 3'h0) |=> !mf_req_b;
    endproperty
    a_no_req: assert property (p_no_req) else $error("disabled request seen");

    // Unimplemented bits stay zero
    property p_unimpl;
        @(posedge hclk) disable iff (!hresetn)
        (grp_b[7] == 1'b0) && (grp_b[3] == 1'b0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

    // Disabled flag stays set without software write
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (grp_b[`B_LV_FLAG] && !wr_b) |=> grp_b[`B_LV_FLAG];
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");

    // New flag raises wake two cycles after its event
    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (ev.low_volt && !grp_b[`B_LV_FLAG]) |=> ##1 wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing");

    // Serial event sets bit 4 of group A
    property p_serial;
        @(posedge hclk) disable iff (!hresetn)
        ev.serial_if |=> grp_a[`A_SI_FLAG];
    endproperty
    a_serial: assert property (p_serial) else $error("serial flag not set");

    // EEPROM event sets bit 5 of group B
    property p_eeprom;
        @(posedge hclk) disable iff (!hresetn)
        ev.eeprom |=> grp_b[`B_EE_FLAG];
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("eeprom flag not set");

    // Low-voltage event sets bit 4 of group B
    property p_low_volt;
        @(posedge hclk) disable iff (!hresetn)
        ev.low_volt |=> grp_b[`B_LV_FLAG];
    endproperty
    a_low_volt: assert property (p_low_volt) else $error("low-voltage flag not set");

    // Second SPI event sets bit 6 of group B
    property p_second_spi;
        @(posedge hclk) disable iff (!hresetn)
        ev.second_spi |=> grp_b[`B_SPI_FLAG];
    endproperty
    a_second_spi: assert property (p_second_spi) else $error("spi flag not set");

    // Timer-3 A event sets bit 7 on the large variant
    property p_t3a_set;
        @(posedge hclk) disable iff (!hresetn)
        (ev.timer3_cmp_a && LARGE_VARIANT) |=> grp_a[`A_T3A_FLAG];
    endproperty
    a_t3a_set: assert property (p_t3a_set) else $error("timer A flag not set");

    // Timer-3 P event sets bit 6 on the large variant
    property p_t3p_set;
        @(posedge hclk) disable iff (!hresetn)
        (ev.timer3_cmp_p && LARGE_VARIANT) |=> grp_a[`A_T3P_FLAG];
    endproperty
    a_t3p_set: assert property (p_t3p_set) else $error("timer P flag not set");

    // Group A bits outside the variant's mask stay zero
    property p_unimpl_a;
        @(posedge hclk) disable iff (!hresetn)
        (grp_a & ~MASK_A) == 8'h00;
    endproperty
    a_unimpl_a: assert property (p_unimpl_a) else $error("group a spare bit set");

    // Serial flag with its enable gives group A request
    property p_serial_req;
        @(posedge hclk) disable iff (!hresetn)
        (grp_a[`A_SI_FLAG] && grp_a[`A_SI_EN]) |=> mf_req_a;
    endproperty
    a_serial_req: assert property (p_serial_req) else $error("serial request missing");

    // Any enabled flag of group B gives its request
    property p_req_b;
        @(posedge hclk) disable iff (!hresetn)
        ((grp_b[6:4] & grp_b[2:0]) != 3'h0) |=> mf_req_b;
    endproperty
    a_req_b: assert property (p_req_b) else $error("group b request missing");

    // No enabled flag in group A, no request
    property p_no_req_a;
        @(posedge hclk) disable iff (!hresetn)
        ((grp_a[7:4] & grp_a[3:0]) == 4'h0) |=> !mf_req_a;
    endproperty
    a_no_req_a: assert property (p_no_req_a) else $error("group a request unexpected");

    // External flag stays set without a software write
    property p_hold_a;
        @(posedge hclk) disable iff (!hresetn)
        (grp_a[`A_XP_FLAG] && !wr_a) |=> grp_a[`A_XP_FLAG];
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("external flag dropped");

    // New external flag raises wake two cycles after its event
    property p_wake_a;
        @(posedge hclk) disable iff (!hresetn)
        (ev.ext_periph && !grp_a[`A_XP_FLAG]) |=> ##1 wake;
    endproperty
    a_wake_a: assert property (p_wake_a) else $error("wake missing for group a");

    // Interrupt output follows enabled sticky status
    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        irq == |(s_q.ist & s_q.ien);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    // Group A request rising sets its sticky status bit
    property p_status_rise;
        @(posedge hclk) disable iff (!hresetn)
        (comb_a && !s_q.req_a) |=> s_q.ist[`ST_GROUP_A];
    endproperty
    a_status_rise: assert property (p_status_rise) else $error("status not set");

endmodule : mfi_regs

/* File: verif/mfi_event_src.sv */
// Peripheral event sources: bench triggers become strobes one clock later
`timescale 1ns/1ps

module mfi_event_src
    import mfi_pkg::*;
(
    input  wire logic        hclk,     // System clock
    input  wire logic        hresetn,  // Async reset, active low
    input  wire src_events_t trig,     // Events asked for by the bench
    output src_events_t      ev        // Strobes toward the block
);
    // A request turns into a strobe at the next edge, silent in reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ev <= '0;
        else
            ev <= trig;
    end
endmodule : mfi_event_src

/* File: verif/mfi_regs_bench.sv */
// Self-checking bench for the multi-function interrupt register block
`timescale 1ns/1ps
`include "mfi_cfg.svh"

module mfi_regs_bench;
    import mfi_pkg::*;
    logic        hclk = 1'b0;         // System clock
    logic        hresetn = 1'b0;      // Reset, active low
    logic        hsel, hwrite;        // Select and direction
    logic [7:0]  haddr;               // Byte address
    logic [1:0]  htrans;              // Transfer type
    logic [31:0] hwdata, hrdata;      // Bus data
    wire         hready;              // Slave ready fed back
    logic        hresp, mf_req_a, mf_req_b, wake, irq; // Block outputs
    src_events_t trig, ev;            // Event requests and strobes
    logic [7:0]  ea, eb;              // Expected group contents
    logic [31:0] r, rd, seed = 32'h93da; // Random word, read data, state
    int          error_cnt = 0, n_checks = 0, wake_cnt = 0, snap; // Counters

    mfi_event_src mfi_event_src_i (.hclk(hclk), .hresetn(hresetn), .trig(trig), .ev(ev));
    mfi_regs mfi_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ev(ev), .mf_req_a(mf_req_a),
        .mf_req_b(mf_req_b), .wake(wake), .irq(irq));

    // Clock and wake pulse counter
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (wake === 1'b1) wake_cnt++;

    // Xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Group request expected from flags and enables
    function automatic logic exp_req(input logic [7:0] v);
        return |(v[7:4] & v[3:0]);
    endfunction : exp_req

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One single AHB-Lite transfer, waits on hready at both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rd);
        chk(rd, e);
        chk(hresp, 1'b0);
    endtask : rd_chk

    // One strobe through the partner, then let it settle
    task automatic fire(input src_events_t t);
        trig <= t;
        @(posedge hclk);
        trig <= '0;
        repeat (6) @(posedge hclk);
    endtask : fire

    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Watchdog against a hung bus
    initial
    begin
        #500000;
        error_cnt++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {hsel, hwrite, haddr, htrans, hwdata, trig} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ea = 8'h00;
        eb = 8'h00;
        rd_chk(`OFS_GROUP_A, 32'h0);
        rd_chk(`OFS_GROUP_B, 32'h0);
        chk({mf_req_a, mf_req_b, irq}, 32'h0);
        // Random writes mixed with random events
        repeat (40)
        begin
            r = rnd();
            wr(r[8] ? `OFS_GROUP_B : `OFS_GROUP_A, r);
            if (r[8]) eb = r[7:0] & `MASK_B;
            else ea = r[7:0];
            repeat (3) @(posedge hclk);
            snap = wake_cnt;
            fire(r[22:16]);
            chk(wake_cnt != snap, ((r[22:19] & ~ea[7:4]) | (r[18:16] & ~eb[6:4])) != 0);
            ea |= {r[22:19], 4'h0};
            eb |= {1'b0, r[18:16], 4'h0};
            chk(mf_req_a, exp_req(ea));
            chk(mf_req_b, exp_req(eb));
            rd_chk(`OFS_GROUP_A, {24'h0, ea});
            rd_chk(`OFS_GROUP_B, {24'h0, eb});
        end
        // Disabled source, then interrupt raise, mask and clear
        wr(`OFS_GROUP_A, 32'h0);
        wr(`OFS_GROUP_B, 32'h0);
        wr(`OFS_IRQ_CLEAR, 32'h3);
        wr(`OFS_IRQ_ENABLE, 32'hffff_ffff);
        rd_chk(`OFS_IRQ_ENABLE, 32'h3);
        rd_chk(`OFS_IRQ_STATUS, 32'h0);
        fire(7'h10);
        chk(mf_req_a, 1'b0);
        rd_chk(`OFS_GROUP_A, 32'h20);
        rd_chk(`OFS_WAKE_STATUS, 32'h2);
        chk(irq, 1'b0);
        wr(`OFS_GROUP_A, 32'h22);
        repeat (5) @(posedge hclk);
        chk(mf_req_a, 1'b1);
        chk(irq, 1'b1);
        rd_chk(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b0);
        wr(`OFS_IRQ_STATUS, 32'h3);
        rd_chk(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        rd_chk(`OFS_IRQ_STATUS, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        rd_chk(8'h18, 32'h0);
        rd_chk(`OFS_GROUP_A, 32'h22);
        end_of_test();
    end
endmodule : mfi_regs_bench
